//--- hw/igb_pkg.sv
// constants shared by the input capture gearbox files
package igb_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses)
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 4;
  localparam logic [3:0]  CTRL_ADDR   = 4'h0;
  localparam logic [3:0]  STATUS_ADDR = 4'h4;
  // control fields
  localparam int          CTRL_MODE_LO = 0;
  localparam int          CTRL_MODE_HI = 1;
  localparam int          CTRL_MEM_BIT = 2;
  localparam int          CTRL_DLY_BIT = 3;
  localparam int          CTRL_DYN_BIT = 4;
  localparam logic [4:0]  CTRL_RESET   = 5'h00;
  // status fields
  localparam int          ST_WORD_LO  = 0;
  localparam int          ST_LVL_LO   = 4;
  localparam int          ST_OVR_BIT  = 8;
  localparam int          ST_SDR_BIT  = 9;
  // ---------------------------------------------------------------
  // capture modes as stored in the control register
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_SDR  = 2'h0;
  localparam logic [1:0]  MODE_DDR  = 2'h1;
  localparam logic [1:0]  MODE_GEAR = 2'h2;
  // ---------------------------------------------------------------
  // data path sizing
  // ---------------------------------------------------------------
  localparam int          DLY_TAPS    = 16;
  localparam logic [3:0]  FIXED_TAP   = 4'h3;
  localparam int          WORD_W      = 4;
  localparam int          FIFO_DEPTH  = 8;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

//--- hw/igb_sync.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ps
module igb_sync #(
  parameter int W = 1
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  // ---------------------------------------------------------------
  // synchroniser stages
  // ---------------------------------------------------------------
  logic [W-1:0] meta_q;

  // first stage feeds only the second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // igb_sync

//--- hw/igb_fifo.sv
// small synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
module igb_fifo #(
  parameter int W = 4,
  parameter int D = 8
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic           in_valid,
  output logic                in_ready,
  input  wire logic [W-1:0]   in_data,
  output logic                out_valid,
  input  wire logic           out_ready,
  output logic      [W-1:0]   out_data,
  output logic [$clog2(D):0]  level
);
  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem_q [D];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic          push;
  logic          pop;

  // honest flags straight from the fill count
  assign in_ready  = (level != D[AW:0]);
  assign out_valid = (level != '0);
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q];

  // pointers wrap at the depth, which need not be a power of two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q  <= '0;
      rd_q  <= '0;
      level <= '0;
    end else begin
      if (push)
        wr_q <= (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
      if (pop)
        rd_q <= (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
      level <= level + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  // entries cleared at reset so nothing stale is shown before the write pointer first wraps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < D; i++) mem_q[i] <= '0;
    end else if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule // igb_fifo

//--- hw/igb_capture.sv
// input capture block: bypass, delay, sdr, ddr and gearbox capture
// What this block does
// [R1] pad input bypasses registers to combinational outputs
// [R2] optional delay: fixed tap or four-bit dynamic
// [R3] exactly three capture modes: sdr, ddr, gearbox
// [R4] sdr registers input on the system clock
// [R5] ddr samples on both capture clock edges
// [R6] strobe clock in memory mode, else edge clock
// [R7] ddr streams resynchronised to system clock
// [R8] gearbox yields four streams from one pad
// [R9] gearbox pairs staged on the selected capture clock (strobe in memory mode, else edge), then system
// [R10] polarity input picks the sync clock edge
// [R11] transfer latch gates gearbox word transfer
// [R12] read-control logic supplies clock, polarity, latch
// [R13] reset clears all capture and sync registers
`timescale 1ns/1ps
module igb_capture #(
  parameter int DEPTH = igb_pkg::FIFO_DEPTH
) (
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // pad side and read-control inputs
  input  wire logic                      pad_input_data,
  input  wire logic [3:0]                dynamic_delay_sel,
  input  wire logic                      strobe_derived_capture_clock,
  input  wire logic                      edge_capture_clock,
  input  wire logic                      sync_clock_polarity,
  input  wire logic                      sync_transfer_latch,
  // bypass outputs
  output logic                           comb_bypass_out,
  output logic                           clock_bypass_out,
  output logic                           strobe_delay_in,
  // core side
  output logic                           sdr_data_out,
  output logic                           core_valid,
  input  wire logic                      core_ready,
  output logic                           gear_rise_a,
  output logic                           gear_fall_a,
  output logic                           gear_rise_b,
  output logic                           gear_fall_b,
  // axi4-lite slave
  input  wire logic [igb_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [igb_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  typedef enum logic {GEAR_FIRST, GEAR_SECOND} igb_gear_type;

  localparam int LW = $clog2(DEPTH) + 1;
  logic [4:0]                  ctrl_q;
  logic                        overrun_q;
  logic                        aw_hold_q;
  logic                        w_hold_q;
  logic [igb_pkg::ADDR_W-1:0]  awaddr_q;
  logic [31:0]                 wdata_q;
  logic [3:0]                  wstrb_q;
  logic                        do_write;
  logic                        clr_overrun;
  logic [31:0]                 rd_mux;
  logic [1:0]                  mode;
  logic [8:0]                  pins_s;
  logic                        pad_s;
  logic                        strobe_s;
  logic                        edge_s;
  logic                        pol_s;
  logic                        latch_s;
  logic [3:0]                  dsel_s;
  logic [igb_pkg::DLY_TAPS-1:0] dly_line_q;
  logic                        data_in;
  logic                        cap_s;
  logic                        cap_d_q;
  logic                        cap_rise;
  logic                        cap_fall;
  logic                        sync_edge;
  logic                        rise_q;
  logic                        fall_q;
  logic                        sdr_q;
  logic [1:0]                  gpa_q;
  igb_gear_type                gear_st_q;
  logic                        push_q;
  logic [igb_pkg::WORD_W-1:0]  push_word_q;
  logic [igb_pkg::WORD_W-1:0]  last_word_q;
  logic                        fifo_in_ready;
  logic [igb_pkg::WORD_W-1:0]  fifo_out;
  logic [LW-1:0]               fifo_level;

  assign mode = ctrl_q[igb_pkg::CTRL_MODE_HI:igb_pkg::CTRL_MODE_LO];

  // ---------------------------------------------------------------
  // bypass paths
  // ---------------------------------------------------------------
  // no register here on purpose: these are the raw buffered pad
  assign comb_bypass_out  = pad_input_data; // [R1]
  assign clock_bypass_out = pad_input_data; // [R1]
  assign strobe_delay_in  = pad_input_data; // [R1]

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  // capture clocks are slow link clocks here, sampled like data
  igb_sync #(.W(9)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({dynamic_delay_sel, sync_transfer_latch, sync_clock_polarity,
                edge_capture_clock, strobe_derived_capture_clock,
                pad_input_data}),
    .sync_out (pins_s)
  );
  assign pad_s    = pins_s[0];
  assign strobe_s = pins_s[1]; // [R12]
  assign edge_s   = pins_s[2];
  assign pol_s    = pins_s[3]; // [R12]
  assign latch_s  = pins_s[4]; // [R12]
  assign dsel_s   = pins_s[8:5];

  // ---------------------------------------------------------------
  // input delay line
  // ---------------------------------------------------------------
  // tap k holds the pad k+1 cycles late; delay is in system cycles
  always_ff @(posedge aclk) begin
    if (!aresetn)
      dly_line_q <= '0;
    else
      dly_line_q <= {dly_line_q[igb_pkg::DLY_TAPS-2:0], pad_s};
  end

  // fixed tap or the dynamic select picks the delayed sample
  always_comb begin
    if (!ctrl_q[igb_pkg::CTRL_DLY_BIT])
      data_in = pad_s;
    else if (ctrl_q[igb_pkg::CTRL_DYN_BIT])
      data_in = dly_line_q[dsel_s]; // [R2]
    else
      data_in = dly_line_q[igb_pkg::FIXED_TAP]; // [R2]
  end

  // ---------------------------------------------------------------
  // capture clock edge detection
  // ---------------------------------------------------------------
  // memory mode uses the strobe clock, generic ddr the edge clock
  assign cap_s = ctrl_q[igb_pkg::CTRL_MEM_BIT] ? strobe_s : edge_s; // [R6]

  always_ff @(posedge aclk) begin
    if (!aresetn)
      cap_d_q <= 1'b0;
    else
      cap_d_q <= cap_s;
  end

  assign cap_rise  = cap_s && !cap_d_q;
  assign cap_fall  = !cap_s && cap_d_q;
  // polarity chooses which edge moves the pair into system domain
  assign sync_edge = pol_s ? cap_fall : cap_rise; // [R10]

  // ---------------------------------------------------------------
  // sdr and ddr sample registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sdr_q <= 1'b0; // [R13]
    end else if (mode == igb_pkg::MODE_SDR) begin
      sdr_q <= data_in; // [R4]
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rise_q <= 1'b0; // [R13]
      fall_q <= 1'b0;
    end else if (mode != igb_pkg::MODE_SDR) begin
      if (cap_rise)
        rise_q <= data_in; // [R5]
      if (cap_fall)
        fall_q <= data_in; // [R5]
    end
  end

  // ---------------------------------------------------------------
  // resynchronisation and gearbox
  // ---------------------------------------------------------------
  // pair a is held on the capture clock until pair b arrives; a
  // closed transfer latch slides the window so alignment is chosen
  // by the read-control logic, at the cost of dropped pairs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gpa_q       <= '0; // [R13]
      gear_st_q   <= GEAR_FIRST;
      push_q      <= 1'b0;
      push_word_q <= '0;
    end else begin
      push_q <= 1'b0;
      if (sync_edge && mode == igb_pkg::MODE_DDR) begin
        push_q      <= 1'b1; // [R7]
        push_word_q <= {2'b00, fall_q, rise_q}; // [R7]
      end else if (sync_edge && mode == igb_pkg::MODE_GEAR) begin
        case (gear_st_q)
          GEAR_FIRST: begin
            gpa_q     <= {fall_q, rise_q}; // [R9]
            gear_st_q <= GEAR_SECOND;
          end
          GEAR_SECOND: begin
            if (latch_s) begin
              push_q      <= 1'b1; // [R11]
              push_word_q <= {fall_q, rise_q, gpa_q}; // [R8]
              gear_st_q   <= GEAR_FIRST;
            end else begin
              gpa_q <= {fall_q, rise_q};
            end
          end
          default: gear_st_q <= GEAR_FIRST;
        endcase
      end
      if (mode != igb_pkg::MODE_GEAR)
        gear_st_q <= GEAR_FIRST;
    end
  end

  // ---------------------------------------------------------------
  // system clock output buffer
  // ---------------------------------------------------------------
  // the pad cannot be stalled, so a full buffer costs a word
  igb_fifo #(.W(igb_pkg::WORD_W), .D(DEPTH)) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (push_q),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word_q),
    .out_valid (core_valid),
    .out_ready (core_ready),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

  assign gear_rise_a  = fifo_out[0];
  assign gear_fall_a  = fifo_out[1];
  assign gear_rise_b  = fifo_out[2];
  assign gear_fall_b  = fifo_out[3];
  assign sdr_data_out = sdr_q;

  // last accepted word, shown in status
  always_ff @(posedge aclk) begin
    if (!aresetn)
      last_word_q <= '0;
    else if (push_q && fifo_in_ready)
      last_word_q <= push_word_q;
  end

  // a lost word sets the flag; set wins over a same-cycle clear
  always_ff @(posedge aclk) begin
    if (!aresetn)
      overrun_q <= 1'b0;
    else if (push_q && !fifo_in_ready)
      overrun_q <= 1'b1;
    else if (clr_overrun)
      overrun_q <= 1'b0;
  end

  // ---------------------------------------------------------------
  // axi4-lite write channel
  // ---------------------------------------------------------------
  assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;
  assign do_write      = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign clr_overrun   = do_write && awaddr_q == igb_pkg::STATUS_ADDR &&
                         wstrb_q[1] && wdata_q[igb_pkg::ST_OVR_BIT];

  // address and data are caught in either order, answered together
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= '0;
      wdata_q      <= '0;
      wstrb_q      <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= igb_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_q == igb_pkg::CTRL_ADDR ||
                         awaddr_q == igb_pkg::STATUS_ADDR) ?
                        igb_pkg::RESP_OKAY : igb_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // control register; an illegal mode code leaves the mode alone
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= igb_pkg::CTRL_RESET;
    end else if (do_write && awaddr_q == igb_pkg::CTRL_ADDR && wstrb_q[0]) begin
      ctrl_q[4:2] <= wdata_q[4:2];
      if (wdata_q[1:0] != 2'b11)
        ctrl_q[1:0] <= wdata_q[1:0]; // [R3]
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite read channel
  // ---------------------------------------------------------------
  always_comb begin
    rd_mux = '0;
    if (s_axi_araddr == igb_pkg::CTRL_ADDR) begin
      rd_mux[4:0] = ctrl_q;
    end else begin
      rd_mux[igb_pkg::ST_WORD_LO +: 4]  = last_word_q;
      rd_mux[igb_pkg::ST_LVL_LO +: LW]  = fifo_level;
      rd_mux[igb_pkg::ST_OVR_BIT]       = overrun_q;
      rd_mux[igb_pkg::ST_SDR_BIT]       = sdr_q;
    end
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= igb_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= (s_axi_araddr == igb_pkg::CTRL_ADDR ||
                       s_axi_araddr == igb_pkg::STATUS_ADDR) ?
                      igb_pkg::RESP_OKAY : igb_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_bypass;
    comb_bypass_out == pad_input_data && clock_bypass_out == pad_input_data;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass differs from pad"); // [R1]

  property p_fixed_delay;
    ctrl_q[igb_pkg::CTRL_DLY_BIT] && !ctrl_q[igb_pkg::CTRL_DYN_BIT] && $past(aresetn, 5)
      |-> data_in == $past(pad_s, 4);
  endproperty
  a_fixed_delay: assert property (p_fixed_delay) else $error("fixed delay wrong"); // [R2]

  property p_mode_legal;
    mode != 2'b11;
  endproperty
  a_mode_legal: assert property (p_mode_legal) else $error("illegal mode"); // [R3]

  property p_sdr;
    mode == igb_pkg::MODE_SDR |=> sdr_q == $past(data_in);
  endproperty
  a_sdr: assert property (p_sdr) else $error("sdr sample missed"); // [R4]

  property p_ddr_rise;
    mode != igb_pkg::MODE_SDR && cap_s && !cap_d_q |=> rise_q == $past(data_in);
  endproperty
  a_ddr_rise: assert property (p_ddr_rise) else $error("rising sample missed"); // [R5]

  property p_pol;
    push_q |-> $past(pol_s ? (!cap_s && cap_d_q) : (cap_s && !cap_d_q));
  endproperty
  a_pol: assert property (p_pol) else $error("push on wrong edge"); // [R10]

  property p_ddr_word;
    mode == igb_pkg::MODE_DDR && sync_edge |=> push_q && push_word_q ==
      {2'b00, $past(fall_q), $past(rise_q)};
  endproperty
  a_ddr_word: assert property (p_ddr_word) else $error("ddr word wrong"); // [R7]

  property p_gear_latch;
    mode == igb_pkg::MODE_GEAR && push_q |-> $past(latch_s) &&
      push_word_q[1:0] == $past(gpa_q);
  endproperty
  a_gear_latch: assert property (p_gear_latch) else $error("gear transfer unlatched"); // [R11]

  // looked at on the first edge out of reset, where the disable no longer hides it
  property p_reset_clear;
    $rose(aresetn) |-> rise_q == 1'b0 && fall_q == 1'b0 && gpa_q == 2'b00 &&
      sdr_q == 1'b0 && !push_q;
  endproperty
  a_reset_clear: assert property (@(posedge aclk) p_reset_clear) // [R13]
    else $error("capture not cleared");

  c_ddr_push:  cover property (mode == igb_pkg::MODE_DDR && push_q);
  c_gear_push: cover property (mode == igb_pkg::MODE_GEAR && push_q);
  c_overrun:   cover property (push_q && !fifo_in_ready);
endmodule // igb_capture

//--- verif/igb_partner.sv
// far-side model: pad input buffer and strobe read-control logic
`timescale 1ns/1ps
module igb_partner (
  input  wire logic use_strobe,
  input  wire logic pol_cfg,
  input  wire logic lat_cfg,
  output logic      pad_input_data,
  output logic      strobe_derived_capture_clock,
  output logic      edge_capture_clock,
  output logic      sync_clock_polarity,
  output logic      sync_transfer_latch
);
  logic cap;
  // only the selected capture clock runs; the other one stands low
  assign strobe_derived_capture_clock = use_strobe & cap;
  assign edge_capture_clock           = ~use_strobe & cap;
  assign sync_clock_polarity          = pol_cfg;
  assign sync_transfer_latch          = lat_cfg;
  // clock stands still outside frames
  initial begin
    cap = 1'b0;
    pad_input_data = 1'b1;
  end
  // data sits a quarter period either side of each capture edge
  task automatic send_frame(input logic r, input logic f, input int n);
    repeat (n) begin
      pad_input_data = r;
      #100 cap = 1'b1;
      #100 pad_input_data = f;
      #100 cap = 1'b0;
      #100;
    end
    pad_input_data = ~f; // released line shows the inverse, never a stale bit
  endtask
endmodule // igb_partner

//--- verif/test_ddr_input_capture_gearbox.sv
// self-checking bench for the input capture gearbox
`timescale 1ns/1ps
module test_ddr_input_capture_gearbox;
  logic        aclk, aresetn, core_ready, use_strobe, pol_cfg, lat_cfg;
  logic [3:0]  dynamic_delay_sel, s_axi_awaddr, s_axi_araddr, s_axi_wstrb, w;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        pad_input_data, strobe_derived_capture_clock, edge_capture_clock;
  logic        sync_clock_polarity, sync_transfer_latch, comb_bypass_out, clock_bypass_out;
  logic        strobe_delay_in, sdr_data_out, core_valid;
  logic        gear_rise_a, gear_fall_a, gear_rise_b, gear_fall_b;
  int          n_mismatch = 0, checks = 0, cyc = 0, n;

  igb_capture #(.DEPTH(8)) i_dut (.aclk, .aresetn, .pad_input_data, .dynamic_delay_sel,
    .strobe_derived_capture_clock, .edge_capture_clock, .sync_clock_polarity,
    .sync_transfer_latch, .comb_bypass_out, .clock_bypass_out, .strobe_delay_in,
    .sdr_data_out, .core_valid, .core_ready, .gear_rise_a, .gear_fall_a, .gear_rise_b,
    .gear_fall_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  igb_partner i_far (.use_strobe, .pol_cfg, .lat_cfg, .pad_input_data,
    .strobe_derived_capture_clock, .edge_capture_clock, .sync_clock_polarity,
    .sync_transfer_latch);

  // ---------------------------------------------------------------
  // checking and bus tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // address and data offered together, each released once taken
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic aw_t, w_t;
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready === 1'b1) begin
        aw_t = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready === 1'b1) begin
        w_t = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [3:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic ctrl(input logic [4:0] v);
    axw(igb_pkg::CTRL_ADDR, {27'h0, v}, 4'hF);
  endtask
  // frame starts off the clock edge so the two clocks stay out of phase
  task automatic frame(input logic r, input logic f, input int k);
    @(posedge aclk);
    #7;
    i_far.send_frame(r, f, k);
    repeat (12) @(posedge aclk);
  endtask
  task automatic word_is(input logic [3:0] e);
    axr(igb_pkg::STATUS_ADDR);
    chk(rd[3:0], e);
  endtask

  // ---------------------------------------------------------------
  // clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // cut a hang short well past the expected run length
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    {aresetn, use_strobe, pol_cfg, dynamic_delay_sel} = '0;
    {core_ready, lat_cfg} = 2'h3;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axr(igb_pkg::STATUS_ADDR);
    chk(rd[8:0], 9'h000);
    axw(4'h8, 32'hFFFF_FFFF, 4'hF);
    chk(rsp, igb_pkg::RESP_SLVERR);
    axr(4'hC);
    chk(rsp, igb_pkg::RESP_SLVERR);
    axr(igb_pkg::CTRL_ADDR);
    chk(rd, 32'h0);
    // sdr: pad idles at the inverse of the last frame bit
    for (int i = 0; i < 2; i++) begin
      frame(i[0], ~i[0], 4);
      chk(sdr_data_out, i[0]);
      chk({comb_bypass_out, clock_bypass_out, strobe_delay_in}, {3{i[0]}});
      axr(igb_pkg::STATUS_ADDR);
      chk(rd[9:4], {i[0], 5'h00});
    end
    ctrl(5'h01);
    ctrl(5'h03);
    axr(igb_pkg::CTRL_ADDR);
    chk(rd[4:0], 5'h01);
    for (int i = 0; i < 4; i++) begin
      frame(i[0], i[1], 4);
      word_is({2'h0, i[1:0]});
    end
    // strobe clock counts only in memory mode
    use_strobe <= 1'b1;
    frame(1'b1, 1'b0, 4);
    word_is(4'h3);
    ctrl(5'h05);
    frame(1'b1, 1'b0, 4);
    word_is(4'h1);
    use_strobe <= 1'b0;
    ctrl(5'h01);
    pol_cfg <= 1'b1;
    frame(1'b0, 1'b1, 4);
    word_is(4'h2);
    pol_cfg <= 1'b0;
    // a half-period delay swaps rise and fall samples
    for (int i = 0; i < 3; i++) begin
      ctrl(i == 0 ? 5'h09 : 5'h19);
      dynamic_delay_sel <= (i == 1) ? 4'h3 : 4'h0;
      frame(1'b1, 1'b0, 4);
      word_is(i == 2 ? 4'h1 : 4'h2);
    end
    ctrl(5'h02);
    for (int i = 0; i < 2; i++) begin
      frame(i[0], ~i[0], 6);
      word_is(i[0] ? 4'h5 : 4'hA);
    end
    lat_cfg <= 1'b0;
    frame(1'b0, 1'b1, 6);
    word_is(4'h5);
    lat_cfg <= 1'b1;
    // fill the fifo past full, then drain it with the link idle
    ctrl(5'h01);
    core_ready <= 1'b0;
    frame(1'b1, 1'b0, 12);
    axr(igb_pkg::STATUS_ADDR);
    chk(rd[8:4], 5'h18);
    chk(core_valid, 1'b1);
    core_ready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      if (core_valid === 1'b1) begin
        n++;
        w = {gear_fall_b, gear_rise_b, gear_fall_a, gear_rise_a};
      end
    end while (core_valid !== 1'b0 && n < 20);
    chk(n, 8);
    chk(w, 4'h1);
    axw(igb_pkg::STATUS_ADDR, 32'h0000_0100, 4'h1);
    axr(igb_pkg::STATUS_ADDR);
    chk(rd[8], 1'b1);
    axw(igb_pkg::STATUS_ADDR, 32'h0000_0100, 4'h2);
    chk(rsp, igb_pkg::RESP_OKAY);
    axr(igb_pkg::STATUS_ADDR);
    chk(rd[8:4], 5'h00);
    report_and_stop;
  end
endmodule // test_ddr_input_capture_gearbox
